// *** ddr2_bank_defines.svh ***
`ifndef DDR2_BANK_DEFINES_SVH
`define DDR2_BANK_DEFINES_SVH

// ****************************************************************
// Timing figures in ns and clock rate
// ****************************************************************
`define DDR2_CLK_MHZ    100
`define DDR2_T_RP_NS    15
`define DDR2_T_RCD_NS   15
`define DDR2_T_WR_NS    15
`define DDR2_T_RFC_NS   105

// Least times round up to whole cycles, never below one
`define DDR2_NS2CYC(ns) (((((ns) * `DDR2_CLK_MHZ) + 999) / 1000) < 1 ? 1 : \
                         ((((ns) * `DDR2_CLK_MHZ) + 999) / 1000))
`define DDR2_RP_CYC     `DDR2_NS2CYC(`DDR2_T_RP_NS)
`define DDR2_RCD_CYC    `DDR2_NS2CYC(`DDR2_T_RCD_NS)
`define DDR2_WR_CYC     `DDR2_NS2CYC(`DDR2_T_WR_NS)
`define DDR2_RFC_CYC    `DDR2_NS2CYC(`DDR2_T_RFC_NS)

// ****************************************************************
// Geometry and reset values
// ****************************************************************
`define DDR2_BURST_LEN  4
`define DDR2_NUM_BANKS  4
`define DDR2_TMR_W      8
`define DDR2_TMR_RST    8'h00

`endif

// *** ddr2_bank_pkg.sv ***
package ddr2_bank_pkg;

   // Decoded command on the control pins
   typedef enum logic [2:0] {
      CMD_DESEL,
      CMD_NOP,
      CMD_READ,
      CMD_WRITE,
      CMD_ACT,
      CMD_PRE,
      CMD_REF,
      CMD_MRS
   } cmd_t;

   // Per-bank state
   typedef enum logic [3:0] {
      BK_IDLE,
      BK_ACTIVATING,
      BK_ACTIVE,
      BK_READ,
      BK_WRITE,
      BK_READ_AP,
      BK_WRITE_AP,
      BK_WREC,
      BK_WREC_AP,
      BK_PRECHARGING
   } bank_state_t;

   // Strobe decode; chip select high wins over everything
   function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                       input logic cas_n, input logic we_n);
      cmd_t c;
      c = CMD_NOP;
      if (cs_n) begin
         c = CMD_DESEL;
      end else begin
         unique case ({ras_n, cas_n, we_n})
            3'b111: c = CMD_NOP;
            3'b101: c = CMD_READ;
            3'b100: c = CMD_WRITE;
            3'b011: c = CMD_ACT;
            3'b010: c = CMD_PRE;
            3'b001: c = CMD_REF;
            3'b000: c = CMD_MRS;
            3'b110: c = CMD_NOP;
         endcase
      end
      return c;
   endfunction

endpackage

// *** ddr2_cmd_if.sv ***
`timescale 1ns/1ps
interface ddr2_cmd_if #(parameter int BA_W = 2);
   import ddr2_bank_pkg::*;
   logic      ce;
   cmd_t      cmd;
   logic [BA_W-1:0] ba;
   logic      a10;

   modport src (output ce, output cmd, output ba, output a10);
   modport snk (input ce, input cmd, input ba, input a10);
endinterface

// *** ddr2_bank_fsm.sv ***
`timescale 1ns/1ps
`include "ddr2_bank_defines.svh"
module ddr2_bank_fsm #(
   parameter int                BA_W      = 2,
   parameter logic [BA_W-1:0]   BANK_ID   = '0,
   parameter int                BURST_LEN = `DDR2_BURST_LEN
) (
   // Clock and reset
   input  wire logic                      i_mclk,
   input  wire logic                      i_arst_n,
   // Decoded command
   ddr2_cmd_if.snk                        c,
   // Bank status
   output ddr2_bank_pkg::bank_state_t     o_state,
   output logic                           o_illegal
);
   import ddr2_bank_pkg::*;

   localparam logic [`DDR2_TMR_W-1:0] BURST_CYC = `DDR2_TMR_W'(BURST_LEN / 2 - 1);
   localparam logic [`DDR2_TMR_W-1:0] RP_CYC    = `DDR2_TMR_W'(`DDR2_RP_CYC - 1);
   localparam logic [`DDR2_TMR_W-1:0] RCD_CYC   = `DDR2_TMR_W'(`DDR2_RCD_CYC - 1);
   localparam logic [`DDR2_TMR_W-1:0] WR_CYC    = `DDR2_TMR_W'(`DDR2_WR_CYC - 1);

   bank_state_t             state;
   bank_state_t             next_state;
   logic [`DDR2_TMR_W-1:0]  tmr;
   logic [`DDR2_TMR_W-1:0]  next_tmr;
   logic                    hit;
   logic                    pre_hit;
   logic                    done;
   logic                    is_col;
   logic                    blocked;

   assign hit     = (c.ba == BANK_ID);
   assign pre_hit = (c.cmd == CMD_PRE) && (hit || c.a10);
   assign done    = (tmr == '0);
   assign is_col  = (c.cmd == CMD_READ) || (c.cmd == CMD_WRITE);
   assign blocked = ((is_col || c.cmd == CMD_ACT) && hit) || pre_hit;

   // ****************************************************************
   // Next state; a refused command is ignored, timed exits still occur
   // ****************************************************************
   always_comb begin
      next_state = state;
      next_tmr   = (tmr == '0) ? tmr : tmr - `DDR2_TMR_W'(1);
      o_illegal  = 1'b0;
      // Mode set or refresh is only legal with the bank idle
      if (state != BK_IDLE && (c.cmd == CMD_REF || c.cmd == CMD_MRS)) begin
         o_illegal = 1'b1;
      end
      unique case (state)
         BK_IDLE: begin
            if (c.cmd == CMD_ACT && hit) begin
               next_state = BK_ACTIVATING;
               next_tmr   = RCD_CYC;
            end else if (is_col && hit) begin
               o_illegal = 1'b1;
            end
         end
         BK_ACTIVATING: begin
            // Holding on a refused command would stretch tRCD
            if (blocked) begin
               o_illegal = 1'b1;
            end
            if (done) begin
               next_state = BK_ACTIVE;
            end
         end
         BK_ACTIVE, BK_READ, BK_WRITE, BK_WREC: begin
            if (c.cmd == CMD_READ && hit && state != BK_WRITE && state != BK_WREC) begin
               next_state = c.a10 ? BK_READ_AP : BK_READ;
               next_tmr   = BURST_CYC;
            end else if (c.cmd == CMD_WRITE && hit && state != BK_READ) begin
               next_state = c.a10 ? BK_WRITE_AP : BK_WRITE;
               next_tmr   = BURST_CYC;
            end else if (pre_hit && state == BK_ACTIVE) begin
               next_state = BK_PRECHARGING;
               next_tmr   = RP_CYC;
            end else begin
               if (blocked) begin
                  o_illegal = 1'b1;
               end
               if (done && state == BK_READ) begin
                  next_state = BK_ACTIVE;
               end else if (done && state == BK_WRITE) begin
                  next_state = BK_WREC;
                  next_tmr   = WR_CYC;
               end else if (done && state == BK_WREC) begin
                  next_state = BK_ACTIVE;
               end
            end
         end
         BK_READ_AP, BK_WRITE_AP, BK_WREC_AP: begin
            // Burst runs out on its own; column, activate or precharge commands that hit this bank are refused
            if (blocked) begin
               o_illegal = 1'b1;
            end
            if (done && state == BK_READ_AP) begin
               next_state = BK_PRECHARGING;
               next_tmr   = RP_CYC;
            end else if (done && state == BK_WRITE_AP) begin
               next_state = BK_WREC_AP;
               next_tmr   = WR_CYC;
            end else if (done) begin
               next_state = BK_PRECHARGING;
               next_tmr   = RP_CYC;
            end
         end
         BK_PRECHARGING: begin
            // A further precharge is a no-op and does not restart tRP
            if ((is_col || c.cmd == CMD_ACT) && hit) begin
               o_illegal = 1'b1;
            end
            if (done) begin
               next_state = BK_IDLE;
            end
         end
      endcase
   end

   // ****************************************************************
   // State and timer registers
   // ****************************************************************
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= BK_IDLE;
         tmr   <= `DDR2_TMR_RST;
      end else if (c.ce) begin
         state <= next_state;
         tmr   <= next_tmr;
      end
   end

   assign o_state = state;
endmodule

// *** ddr2_bank_state_command_check.sv ***
`timescale 1ns/1ps
`include "ddr2_bank_defines.svh"
// Functional notes
// - A deselect or no-op during a read with auto-precharge lets the burst run to its end.
// - A deselect or no-op during a write with auto-precharge lets the burst complete.
// - While precharging, deselect, no-op and precharge are no-ops; idle follows after tRP.
// - While activating, deselect or no-op is a no-op; the bank is active after tRCD.
// - After refresh, deselect or no-op is a no-op and idle returns after tRFC.
module ddr2_bank_state_command_check #(
   parameter int BA_W      = 2,
   parameter int NUM_BANKS = `DDR2_NUM_BANKS,
   parameter int BURST_LEN = `DDR2_BURST_LEN
) (
   // Clock, reset, enable
   input  wire logic                         i_mclk,
   input  wire logic                         i_arst_n,
   input  wire logic                         i_ce,
   // Command pins
   input  wire logic                         i_cs_n,
   input  wire logic                         i_ras_n,
   input  wire logic                         i_cas_n,
   input  wire logic                         i_we_n,
   input  wire logic [BA_W-1:0]              i_ba,
   input  wire logic                         i_a10,
   // Status
   output ddr2_bank_pkg::bank_state_t        o_bank_state [NUM_BANKS],
   output logic                              o_refreshing,
   output logic                              o_all_idle,
   output logic                              o_illegal
);
   import ddr2_bank_pkg::*;

   localparam logic [`DDR2_TMR_W-1:0] RFC_CYC = `DDR2_TMR_W'(`DDR2_RFC_CYC - 1);

   ddr2_cmd_if #(.BA_W(BA_W)) cmd_bus ();

   bank_state_t             bank_st [NUM_BANKS];
   cmd_t                    pin_cmd;
   logic [NUM_BANKS-1:0]    bank_bad;
   logic                    banks_idle;
   logic                    ref_bad;
   logic                    rfc_bad;
   logic                    next_illegal;
   logic [`DDR2_TMR_W-1:0]  rfc_tmr;

   // ****************************************************************
   // Command decode
   // ****************************************************************
   // Strobes are sampled on the same edge the banks act on
   assign cmd_bus.ce  = i_ce;
   assign pin_cmd     = decode_cmd(i_cs_n, i_ras_n, i_cas_n, i_we_n);
   // Banks see a no-op while refreshing, so a refused command opens no row
   assign cmd_bus.cmd = o_refreshing ? CMD_NOP : pin_cmd;
   assign cmd_bus.ba  = i_ba;
   assign cmd_bus.a10 = i_a10;

   // ****************************************************************
   // Bank trackers
   // ****************************************************************
   // Each bank judges commands addressed to it, plus any refresh, mode set or precharge with a10 set
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      ddr2_bank_fsm #(
         .BA_W      (BA_W),
         .BANK_ID   (BA_W'(b)),
         .BURST_LEN (BURST_LEN)
      ) u_bank (
         .i_mclk    (i_mclk),
         .i_arst_n  (i_arst_n),
         .c         (cmd_bus),
         .o_state   (bank_st[b]),
         .o_illegal (bank_bad[b])
      );
   end

   always_comb begin
      banks_idle = 1'b1;
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (bank_st[b] != BK_IDLE) begin
            banks_idle = 1'b0;
         end
      end
   end

   // ****************************************************************
   // Refresh cycle
   // ****************************************************************
   // While refreshing, anything but deselect or no-op is refused
   assign rfc_bad = o_refreshing && (pin_cmd != CMD_DESEL) && (pin_cmd != CMD_NOP);
   assign ref_bad = (pin_cmd == CMD_REF) && !banks_idle;

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_refreshing <= 1'b0;
         rfc_tmr      <= `DDR2_TMR_RST;
      end else if (i_ce) begin
         if (o_refreshing) begin
            if (rfc_tmr == '0) begin
               o_refreshing <= 1'b0;
            end else begin
               rfc_tmr <= rfc_tmr - `DDR2_TMR_W'(1);
            end
         end else if (pin_cmd == CMD_REF && banks_idle) begin
            o_refreshing <= 1'b1;
            rfc_tmr      <= RFC_CYC;
         end
      end
   end

   // ****************************************************************
   // Registered status outputs
   // ****************************************************************
   // Flag lags the offending command by one edge; a pulse per offence
   assign next_illegal = (|bank_bad) || ref_bad || rfc_bad;

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_illegal  <= 1'b0;
         o_all_idle <= 1'b1;
      end else if (i_ce) begin
         o_illegal  <= next_illegal;
         o_all_idle <= banks_idle && !o_refreshing;
      end
   end

   // Bank states copied out so the port comes from a flop
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int b = 0; b < NUM_BANKS; b++) begin
            o_bank_state[b] <= BK_IDLE;
         end
      end else if (i_ce) begin
         for (int b = 0; b < NUM_BANKS; b++) begin
            o_bank_state[b] <= bank_st[b];
         end
      end
   end
endmodule

// *** ddr2_bank_check_asserts.sv ***
`timescale 1ns/1ps
module ddr2_bank_check_asserts
   import ddr2_bank_pkg::*;
#(
   parameter int NUM_BANKS = 4
) (
   // Clock and reset
   input  wire logic                  i_mclk,
   input  wire logic                  i_arst_n,
   // Command pins
   input  wire logic                  i_ce,
   input  wire logic                  i_cs_n,
   input  wire logic                  i_ras_n,
   input  wire logic                  i_cas_n,
   input  wire logic                  i_we_n,
   // Status
   input  ddr2_bank_pkg::bank_state_t o_bank_state [NUM_BANKS],
   input  wire logic                  o_refreshing,
   input  wire logic                  o_all_idle,
   input  wire logic                  o_illegal
);
   bank_state_t bs0;
   logic [2:0]  strb;
   logic        cmd_any;
   logic        cmd_ref;
   logic [4:0]  ref_len;

   // Decoded view of the pins; bank 0 carries the state walks
   assign bs0     = o_bank_state[0];
   assign strb    = {i_ras_n, i_cas_n, i_we_n};
   assign cmd_any = i_ce && !i_cs_n && (strb != 3'h7);
   assign cmd_ref = i_ce && !i_cs_n && (strb == 3'h1);

   // Length of the refresh window, cleared once it ends
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ref_len <= 5'h00;
      end else if (o_refreshing) begin
         ref_len <= ref_len + 5'h01;
      end else begin
         ref_len <= 5'h00;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   // Enable low freezes every output, so pending walks are dropped then
   default disable iff (!i_arst_n || !i_ce);

   // ****
   // Checks
   // ****
   ill_cause_a: assert property (o_illegal |-> $past(cmd_any))
      else $error("illegal flag without a command");
   nop_quiet_a: assert property (i_ce && !i_cs_n && strb == 3'h7 |=> !o_illegal)
      else $error("no-op flagged as illegal");
   ref_start_a: assert property ($rose(o_refreshing) |-> $past(cmd_ref) || $past(cmd_ref, 2))
      else $error("refresh window without a refresh");
   ref_len_a: assert property ($fell(o_refreshing) |-> ref_len == 5'h0b)
      else $error("refresh window too short");
   ref_busy_a: assert property (o_refreshing && $past(o_refreshing) |-> !o_all_idle)
      else $error("idle shown during refresh");
   act_path_a: assert property (bs0 == BK_ACTIVATING && $past(bs0) != BK_ACTIVATING
      |-> ##1 bs0 == BK_ACTIVATING ##1 bs0 == BK_ACTIVE)
      else $error("activation walk wrong");
   pre_path_a: assert property (bs0 == BK_PRECHARGING && $past(bs0) != BK_PRECHARGING
      |-> ##1 bs0 == BK_PRECHARGING ##1 bs0 == BK_IDLE)
      else $error("precharge walk wrong");
   rdap_path_a: assert property (bs0 == BK_READ_AP && $past(bs0) != BK_READ_AP
      |-> ##1 bs0 == BK_READ_AP ##1 bs0 == BK_PRECHARGING)
      else $error("read burst walk wrong");
   wrap_path_a: assert property (bs0 == BK_WRITE_AP && $past(bs0) != BK_WRITE_AP
      |-> ##1 bs0 == BK_WRITE_AP ##1 bs0 == BK_WREC_AP)
      else $error("write burst walk wrong");
   wrec_end_a: assert property (bs0 == BK_WREC && $past(bs0) == BK_WREC |=> bs0 != BK_WREC)
      else $error("write recovery too long");

   c_ref: cover property ($rose(o_refreshing));
   c_ill: cover property (o_illegal);
   c_wrap: cover property (bs0 == BK_WREC_AP);
endmodule

bind ddr2_bank_state_command_check ddr2_bank_check_asserts #(.NUM_BANKS(NUM_BANKS)) chk_inst (
   .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n),
   .i_cas_n(i_cas_n), .i_we_n(i_we_n), .o_bank_state(o_bank_state),
   .o_refreshing(o_refreshing), .o_all_idle(o_all_idle), .o_illegal(o_illegal));

// *** ddr2_ctrl_model.sv ***
`timescale 1ns/1ps
module ddr2_ctrl_model
   import ddr2_bank_pkg::*;
(
   // Clock
   input  wire logic  i_mclk,
   // Command pins
   output logic       o_cs_n,
   output logic       o_ras_n,
   output logic       o_cas_n,
   output logic       o_we_n,
   output logic [1:0] o_ba,
   output logic       o_a10
);
   // Pins rest at no-op from time zero
   initial begin
      o_cs_n = 1'b0;
      {o_ras_n, o_cas_n, o_we_n} = 3'h7;
      o_ba = 2'h0;
      o_a10 = 1'b0;
   end

   // One command for one cycle; the order is the bench's
   task automatic issue(input cmd_t c, input logic [1:0] ba, input logic a10);
      o_cs_n = (c == CMD_DESEL);
      case (c)
         CMD_READ:  {o_ras_n, o_cas_n, o_we_n} = 3'h5;
         CMD_WRITE: {o_ras_n, o_cas_n, o_we_n} = 3'h4;
         CMD_ACT:   {o_ras_n, o_cas_n, o_we_n} = 3'h3;
         CMD_PRE:   {o_ras_n, o_cas_n, o_we_n} = 3'h2;
         CMD_REF:   {o_ras_n, o_cas_n, o_we_n} = 3'h1;
         CMD_NOP:   {o_ras_n, o_cas_n, o_we_n} = 3'h7;
         default:   {o_ras_n, o_cas_n, o_we_n} = 3'h0; // Deselect hides a mode set
      endcase
      o_ba = ba;
      o_a10 = a10;
      @(negedge i_mclk);
      // Stale bank and flag bits flip so they are never trusted
      o_cs_n = 1'b0;
      {o_ras_n, o_cas_n, o_we_n} = 3'h7;
      o_ba = ~ba;
      o_a10 = ~a10;
   endtask
endmodule

// *** ddr2_bank_state_command_check_tb_top.sv ***
`timescale 1ns/1ps
module ddr2_bank_state_command_check_tb_top;
   import ddr2_bank_pkg::*;
   logic        i_mclk;
   logic        i_arst_n;
   logic        i_ce;
   logic        cs_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic        a10;
   logic [1:0]  ba;
   bank_state_t bs [4];
   logic        refr;
   logic        all_idle;
   logic        ill;
   int          n_fail;
   int          cmp_count;
   int          ref_cnt;

   // 100 MHz clock
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   ddr2_ctrl_model ddr2_ctrl_model_inst (.i_mclk(i_mclk), .o_cs_n(cs_n), .o_ras_n(ras_n),
      .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_a10(a10));
   ddr2_bank_state_command_check ddr2_bank_state_command_check_inst (.i_mclk(i_mclk),
      .i_arst_n(i_arst_n), .i_ce(i_ce), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
      .i_we_n(we_n), .i_ba(ba), .i_a10(a10), .o_bank_state(bs), .o_refreshing(refr),
      .o_all_idle(all_idle), .o_illegal(ill));

   // Refresh window length, seen where outputs are settled
   always @(negedge i_mclk) begin
      if (refr === 1'b1) ref_cnt++;
   end

   // ****
   // Compare and report
   // ****
   task automatic cmp_st(input bank_state_t got, input bank_state_t exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t state %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic cmp_b(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t flag %b want %b", $time, got, exp);
      end
   endtask
   task automatic cmp_n(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         n_fail++;
         $display("FAIL %0t count %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ****
   // Helpers
   // ****
   task automatic iss(input cmd_t c, input logic [1:0] b, input logic f);
      ddr2_ctrl_model_inst.issue(c, b, f);
   endtask
   // Flag registers on the edge that took the command; seen right after it
   task automatic ill_chk(input logic exp);
      cmp_b(ill, exp);
   endtask
   // Wait for a state, then count its cycles when exp is not negative
   task automatic seq(input int b, input bank_state_t st, input int exp);
      int n;
      n = 0;
      while (bs[b] !== st && n < 20) begin
         @(negedge i_mclk);
         n++;
      end
      if (bs[b] !== st) begin
         cmp_st(bs[b], st);
         print_verdict();
      end
      n = 0;
      while (exp >= 0 && bs[b] === st && n < 20) begin
         @(negedge i_mclk);
         n++;
      end
      if (exp >= 0) cmp_n(n, exp);
   endtask

   // ****
   // Scenarios
   // ****
   task automatic t_act();
      iss(CMD_ACT, 2'h0, 1'b0);
      iss(CMD_DESEL, 2'h0, 1'b0);
      seq(0, BK_ACTIVATING, 2);
      cmp_st(bs[0], BK_ACTIVE);
   endtask
   task automatic t_rdap();
      iss(CMD_READ, 2'h0, 1'b1);
      seq(0, BK_READ_AP, 2);
      iss(CMD_ACT, 2'h0, 1'b0);
      ill_chk(1'b1);
      iss(CMD_ACT, 2'h1, 1'b0);
      ill_chk(1'b0);
      seq(0, BK_IDLE, -1);
      seq(1, BK_ACTIVE, -1);
   endtask
   task automatic t_wrec();
      iss(CMD_ACT, 2'h0, 1'b0);
      seq(0, BK_ACTIVE, -1);
      iss(CMD_WRITE, 2'h0, 1'b0);
      seq(0, BK_WRITE, 2);
      iss(CMD_WRITE, 2'h0, 1'b0);
      ill_chk(1'b0);
      seq(0, BK_WRITE, -1);
      seq(0, BK_WREC, 2);
      cmp_st(bs[0], BK_ACTIVE);
   endtask
   task automatic t_wrap();
      iss(CMD_WRITE, 2'h0, 1'b1);
      seq(0, BK_WRITE_AP, -1);
      iss(CMD_READ, 2'h0, 1'b0);
      ill_chk(1'b1);
      seq(0, BK_WREC_AP, -1);
      iss(CMD_PRE, 2'h0, 1'b0);
      ill_chk(1'b1);
      seq(0, BK_IDLE, -1);
   endtask
   task automatic t_bad_ref();
      iss(CMD_REF, 2'h0, 1'b0);
      ill_chk(1'b1);
      cmp_b(refr, 1'b0);
      iss(CMD_MRS, 2'h0, 1'b0);
      ill_chk(1'b1);
      iss(CMD_PRE, 2'h1, 1'b0);
      iss(CMD_PRE, 2'h1, 1'b1);
      ill_chk(1'b0);
      cmp_st(bs[1], BK_PRECHARGING);
      @(negedge i_mclk);
      cmp_st(bs[1], BK_PRECHARGING);
      @(negedge i_mclk);
      cmp_st(bs[1], BK_IDLE);
   endtask
   task automatic t_ref();
      int n;
      ref_cnt = 0;
      iss(CMD_REF, 2'h0, 1'b0);
      iss(CMD_ACT, 2'h2, 1'b0);
      ill_chk(1'b1);
      n = 0;
      while (all_idle !== 1'b1 && n < 30) begin
         @(negedge i_mclk);
         n++;
      end
      cmp_b(n < 30, 1'b1);
      cmp_n(ref_cnt, 11);
      cmp_st(bs[2], BK_IDLE);
   endtask
   task automatic t_ce_rst();
      iss(CMD_ACT, 2'h0, 1'b0);
      @(negedge i_mclk);
      // Enable low must hold tRCD where it stands
      i_ce = 1'b0;
      repeat (3) @(negedge i_mclk);
      cmp_st(bs[0], BK_ACTIVATING);
      i_ce = 1'b1;
      @(negedge i_mclk);
      cmp_st(bs[0], BK_ACTIVATING);
      @(negedge i_mclk);
      cmp_st(bs[0], BK_ACTIVE);
      // Reset in mid-run, then a command on the first edge after release
      i_arst_n = 1'b0;
      repeat (2) @(negedge i_mclk);
      cmp_st(bs[0], BK_IDLE);
      cmp_b(all_idle, 1'b1);
      i_arst_n = 1'b1;
      iss(CMD_ACT, 2'h0, 1'b0);
      seq(0, BK_ACTIVATING, 2);
      cmp_st(bs[0], BK_ACTIVE);
   endtask

   // Main sequence
   initial begin
      i_arst_n = 1'b0;
      i_ce = 1'b1;
      n_fail = 0;
      cmp_count = 0;
      ref_cnt = 0;
      repeat (20) @(negedge i_mclk);
      i_arst_n = 1'b1;
      cmp_b(all_idle, 1'b1);
      t_act();
      t_rdap();
      t_wrec();
      t_wrap();
      t_bad_ref();
      t_ref();
      t_ce_rst();
      print_verdict();
   end
endmodule
